/* File: common/scr_pkg.sv */
// Package for the serial control register logic: offsets, fields, reset values
package scr_pkg;
  // Register map (byte addresses on the plain register port)
  localparam logic [3:0] SCR_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] SCR_ADDR_STATUS  = 4'h1;
  localparam logic [3:0] SCR_ADDR_FORMAT  = 4'h2;
  localparam logic [3:0] SCR_ADDR_TXHOLD  = 4'h3;
  localparam logic [3:0] SCR_ADDR_RXHOLD  = 4'h4;
  // Control field positions
  localparam int SCR_CTL_TIE  = 7;
  localparam int SCR_CTL_RIE  = 6;
  localparam int SCR_CTL_TE   = 5;
  localparam int SCR_CTL_RE   = 4;
  localparam int SCR_CTL_MULTIPROC_IRQ_EN = 3;
  localparam int SCR_CTL_TX_END_IRQ_EN = 2;
  localparam int SCR_CTL_CLK_SRC_EXT = 1;
  localparam int SCR_CTL_CLK_OUT_EN = 0;
  // Status field positions
  localparam int SCR_ST_TX_EMPTY_FLAG = 7;
  localparam int SCR_ST_RX_FULL_FLAG = 6;
  localparam int SCR_ST_OVERRUN_FLAG = 5;
  localparam int SCR_ST_FER  = 4;
  localparam int SCR_ST_PER  = 3;
  localparam int SCR_ST_TX_END_FLAG = 2;
  localparam int SCR_ST_MPB  = 1;
  localparam int SCR_ST_MPBT = 0;
  // Format field positions
  localparam int SCR_FMT_SYNC = 7;
  localparam int SCR_FMT_CHR  = 6;
  localparam int SCR_FMT_PE   = 5;
  localparam int SCR_FMT_OE   = 4;
  localparam int SCR_FMT_MP   = 2;
  // Reset values
  localparam logic [7:0] SCR_CONTROL_RST = 8'h00;
  localparam logic [7:0] SCR_STATUS_RST  = 8'h84;
  localparam logic [7:0] SCR_FORMAT_RST  = 8'h00;
  localparam logic [7:0] SCR_TXHOLD_RST  = 8'hff;
  localparam logic [7:0] SCR_RXHOLD_RST  = 8'h00;
  // Bit timing: one bit is SCR_BIT_CYCLES system clocks, 16 ticks per bit
  localparam int         SCR_OVERSAMPLE  = 16;
  localparam logic [7:0] SCR_BIT_CYCLES  = 8'h20;
  localparam logic [7:0] SCR_TICK_CYCLES = 8'h02;
  localparam logic [3:0] SCR_TICK_LAST   = 4'hf;
  localparam logic [3:0] SCR_TICK_MID    = 4'h7;
  // Serial engine states
  typedef enum logic [1:0] {SCR_IDLE, SCR_START, SCR_DATA, SCR_STOP} scr_state_e;
endpackage : scr_pkg

/* File: design/scr_serial_control.sv */
// Serial control register with a compact transmit/receive engine behind it
module scr_serial_control (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  input  wire logic                standby_i,
  // Register port
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_write_i,
  input  wire logic                reg_read_i,
  output logic      [7:0]          reg_rdata_o,
  // Serial pins
  input  wire logic                rxd_i,
  output logic                     txd_o,
  input  wire logic                sck_i,
  output logic                     sck_o,
  output logic                     sck_oe_o,
  // Interrupt requests
  output logic                     tx_empty_irq_o,
  output logic                     rx_full_irq_o,
  output logic                     rx_error_irq_o,
  output logic                     tx_end_irq_o
);
  import scr_pkg::*;

  logic [7:0]  serial_control_reg, serial_status_reg, serial_format_reg;
  logic [7:0]  tx_holding_reg, rx_holding_reg, tx_shifter_reg, rx_shifter_reg;
  logic [7:0]  status_seen_reg, rdata_reg;
  logic [1:0]  rxd_sync_reg, sck_sync_reg;
  logic        sck_prev_reg, txd_reg, sck_out_reg, sck_oe_reg;
  logic [3:0]  irq_reg;
  logic [7:0]  div_reg;
  logic [3:0]  tx_tick_reg, rx_tick_reg;
  logic [3:0]  tx_bit_reg, rx_bit_reg;
  logic        tx_extra_reg, rx_extra_reg;
  scr_state_e  tx_state_reg, rx_state_reg;

  // Decoded mode and control fields
  wire sync_mode   = serial_format_reg[SCR_FMT_SYNC];
  wire mp_active   = ~sync_mode & serial_format_reg[SCR_FMT_MP];
  wire multiproc_irq_en_eff    = mp_active & serial_control_reg[SCR_CTL_MULTIPROC_IRQ_EN];
  wire tx_en       = serial_control_reg[SCR_CTL_TE];
  wire rx_en       = serial_control_reg[SCR_CTL_RE];
  wire clk_src_ext = serial_control_reg[SCR_CTL_CLK_SRC_EXT];
  wire clk_out_en  = ~sync_mode & ~clk_src_ext & serial_control_reg[SCR_CTL_CLK_OUT_EN];
  wire par_on      = ~sync_mode & ~mp_active & serial_format_reg[SCR_FMT_PE];
  wire seven_bit   = ~sync_mode & serial_format_reg[SCR_FMT_CHR];
  wire [3:0] nbits = seven_bit ? 4'h7 : 4'h8;
  wire has_extra   = par_on | mp_active;
  wire soft_reset  = ~resetn_i | standby_i;

  // Register port decode
  wire wr_ctl  = reg_write_i & (reg_addr_i == SCR_ADDR_CONTROL);
  wire wr_st   = reg_write_i & (reg_addr_i == SCR_ADDR_STATUS);
  wire wr_fmt  = reg_write_i & (reg_addr_i == SCR_ADDR_FORMAT);
  wire wr_tx   = reg_write_i & (reg_addr_i == SCR_ADDR_TXHOLD);
  wire rd_st   = reg_read_i & (reg_addr_i == SCR_ADDR_STATUS);
  // Flag clears only where a one was read first
  wire [7:0] st_clr = wr_st ? (status_seen_reg & ~reg_wdata_i) : 8'h00;
  // Full flag as it stands after this cycle's clear, so a new character beats the clear
  wire rx_full_now = serial_status_reg[SCR_ST_RX_FULL_FLAG] & ~st_clr[SCR_ST_RX_FULL_FLAG];
  wire [7:0] ctl_wdata = {reg_wdata_i[7:4],
                          reg_wdata_i[SCR_CTL_MULTIPROC_IRQ_EN] & mp_active,
                          reg_wdata_i[2:0]};

  // Clocking: internal divider gives 16 ticks per bit; with an external clock its rising edges tick instead
  wire sck_rise   = sck_sync_reg[1] & ~sck_prev_reg;
  // Tick on the last clock of each tick period; needs a power-of-two tick length
  wire int_tick   = ((div_reg & (SCR_TICK_CYCLES - 8'h01)) == (SCR_TICK_CYCLES - 8'h01));
  wire tick       = clk_src_ext ? sck_rise : int_tick;
  wire sync_ext_edge = sync_mode & clk_src_ext & sck_rise;

  // Transmit: shifter loads only while empty flag is clear
  wire tx_load = tx_en & (tx_state_reg == SCR_IDLE) &
                 ~serial_status_reg[SCR_ST_TX_EMPTY_FLAG];
  wire tx_bit_end = tick & ((sync_mode & clk_src_ext) | (tx_tick_reg == SCR_TICK_LAST));
  wire tx_done = (tx_state_reg == SCR_STOP) & tx_bit_end &
                 (~has_extra | (tx_bit_reg == 4'hf));
  wire tx_sync_done = sync_mode & (tx_state_reg == SCR_DATA) & tx_bit_end &
                      (tx_bit_reg == nbits - 4'h1);
  wire tx_finish = tx_done | tx_sync_done;

  // Receive: sample in the middle of a bit in async mode, on external clock rising edges in sync mode
  wire rx_sample = sync_mode ? sync_ext_edge
                             : (tick & (rx_tick_reg == SCR_TICK_MID));
  wire rx_start = rx_en & (rx_state_reg == SCR_IDLE) &
                  (sync_mode ? sync_ext_edge : ~rxd_sync_reg[1]);
  wire rx_last_data = (rx_state_reg == SCR_DATA) & rx_sample &
                      (rx_bit_reg == nbits - 4'h1);
  wire rx_done = sync_mode ? rx_last_data : ((rx_state_reg == SCR_STOP) & rx_sample);
  wire [7:0] rx_word = sync_mode ? {rxd_sync_reg[1], rx_shifter_reg[7:1]}
                                 : rx_shifter_reg;
  wire rx_mpb  = mp_active & rx_extra_reg;
  wire rx_take = rx_done & ~(multiproc_irq_en_eff & ~rx_mpb);
  wire rx_par_bad = par_on & ((^rx_shifter_reg) ^ rx_extra_reg ^
                              serial_format_reg[SCR_FMT_OE]);
  wire rx_ferr = ~sync_mode & ~rxd_sync_reg[1];

  // Parity of outgoing character
  function automatic logic par_of(input logic [7:0] d, input logic seven, input logic odd);
    par_of = (^(seven ? {1'b0, d[6:0]} : d)) ^ odd;
  endfunction

  // Status next value: hardware sets win over software clears
  logic [7:0] st_next;
  always_comb begin
    st_next = serial_status_reg & ~st_clr;
    if (st_clr[SCR_ST_TX_EMPTY_FLAG]) begin
      st_next[SCR_ST_TX_END_FLAG] = 1'b0;
    end
    if (wr_st) begin
      st_next[SCR_ST_MPBT] = reg_wdata_i[SCR_ST_MPBT];
    end
    if (tx_load) begin
      st_next[SCR_ST_TX_EMPTY_FLAG] = 1'b1;
    end
    if (tx_finish & serial_status_reg[SCR_ST_TX_EMPTY_FLAG]) begin
      st_next[SCR_ST_TX_END_FLAG] = 1'b1;
    end
    if (rx_done & mp_active) begin
      st_next[SCR_ST_MPB] = rx_mpb;
    end
    if (rx_take) begin
      if (rx_full_now) begin
        st_next[SCR_ST_OVERRUN_FLAG] = 1'b1;
      end else begin
        st_next[SCR_ST_RX_FULL_FLAG] = ~rx_ferr & ~rx_par_bad;
        st_next[SCR_ST_FER]  = st_next[SCR_ST_FER] | rx_ferr;
        st_next[SCR_ST_PER]  = st_next[SCR_ST_PER] | rx_par_bad;
      end
    end
    if (~tx_en) begin
      st_next[SCR_ST_TX_EMPTY_FLAG] = 1'b1;
    end
  end

  // Control next value; hardware clear of multiprocessor enable wins
  logic [7:0] ctl_next;
  always_comb begin
    ctl_next = wr_ctl ? ctl_wdata : serial_control_reg;
    if (rx_done & rx_mpb) begin
      ctl_next[SCR_CTL_MULTIPROC_IRQ_EN] = 1'b0;
    end
  end

  // Request levels, each a flag (the error request any of three) gated by its enable
  wire [3:0] irq_next = {
    serial_status_reg[SCR_ST_TX_EMPTY_FLAG] & serial_control_reg[SCR_CTL_TIE],
    serial_status_reg[SCR_ST_RX_FULL_FLAG] & serial_control_reg[SCR_CTL_RIE],
    (|serial_status_reg[SCR_ST_OVERRUN_FLAG:SCR_ST_PER]) &
      serial_control_reg[SCR_CTL_RIE],
    serial_status_reg[SCR_ST_TX_END_FLAG] & serial_control_reg[SCR_CTL_TX_END_IRQ_EN]
  };

  // Read data mux
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      SCR_ADDR_CONTROL: rd_mux = serial_control_reg;
      SCR_ADDR_STATUS:  rd_mux = serial_status_reg;
      SCR_ADDR_FORMAT:  rd_mux = serial_format_reg;
      SCR_ADDR_TXHOLD:  rd_mux = tx_holding_reg;
      SCR_ADDR_RXHOLD:  rd_mux = rx_holding_reg;
      default:          rd_mux = 8'h00;
    endcase
  end

  // Pin direction: clock out in sync internal or async with output enabled
  wire sck_drive = ~clk_src_ext & (sync_mode | clk_out_en);
  wire sck_level = sync_mode ? ~((tx_state_reg == SCR_DATA) & (div_reg < 8'h01))
                             : (div_reg < (SCR_BIT_CYCLES >> 1));

  // Register file and outputs
  always_ff @(posedge clock_i) begin
    if (soft_reset) begin
      serial_control_reg <= SCR_CONTROL_RST;
      serial_status_reg  <= SCR_STATUS_RST;
      serial_format_reg  <= SCR_FORMAT_RST;
      tx_holding_reg     <= SCR_TXHOLD_RST;
      status_seen_reg    <= 8'h00;
      rdata_reg          <= 8'h00;
      irq_reg            <= 4'h0;
      sck_oe_reg         <= 1'b0;
      sck_out_reg        <= 1'b1;
    end else begin
      serial_control_reg <= ctl_next;
      serial_status_reg  <= st_next;
      if (wr_fmt) serial_format_reg <= reg_wdata_i;
      if (wr_tx) tx_holding_reg <= reg_wdata_i;
      // Remember which ones software saw, cleared again on a status write
      status_seen_reg    <= wr_st ? 8'h00 : (rd_st ? (status_seen_reg | serial_status_reg)
                                                   : status_seen_reg);
      rdata_reg          <= reg_read_i ? rd_mux : 8'h00;
      irq_reg            <= irq_next;
      sck_oe_reg         <= sck_drive;
      sck_out_reg        <= sck_level;
    end
  end

  // Pin synchronisers and edge memory
  always_ff @(posedge clock_i) begin
    if (soft_reset) begin
      rxd_sync_reg <= 2'b11;
      sck_sync_reg <= 2'b11;
      sck_prev_reg <= 1'b1;
      div_reg      <= 8'h00;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd_i};
      sck_sync_reg <= {sck_sync_reg[0], sck_i};
      sck_prev_reg <= sck_sync_reg[1];
      div_reg      <= (div_reg == SCR_BIT_CYCLES - 8'h01) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Transmit engine; sync mode has no framing, one bit per external clock rising edge, or per 16 ticks on the internal clock
  always_ff @(posedge clock_i) begin
    if (soft_reset) begin
      tx_state_reg   <= SCR_IDLE;
      tx_shifter_reg <= 8'hff;
      tx_tick_reg    <= 4'h0;
      tx_bit_reg     <= 4'h0;
      tx_extra_reg   <= 1'b0;
      txd_reg        <= 1'b1;
    end else begin
      if (tick) tx_tick_reg <= tx_tick_reg + 4'h1;
      case (tx_state_reg)
        SCR_IDLE: begin
          txd_reg <= 1'b1;
          if (tx_load) begin
            tx_shifter_reg <= tx_holding_reg;
            tx_extra_reg   <= mp_active ? serial_status_reg[SCR_ST_MPBT]
                              : par_of(tx_holding_reg, seven_bit, serial_format_reg[SCR_FMT_OE]);
            tx_tick_reg    <= 4'h0;
            tx_bit_reg     <= 4'h0;
            tx_state_reg   <= sync_mode ? SCR_DATA : SCR_START;
            txd_reg        <= sync_mode ? tx_holding_reg[0] : 1'b0;
          end
        end
        SCR_START: if (tx_bit_end) begin
          tx_state_reg <= SCR_DATA;
          txd_reg      <= tx_shifter_reg[0];
        end
        SCR_DATA: if (tx_bit_end) begin
          tx_shifter_reg <= {1'b1, tx_shifter_reg[7:1]};
          tx_bit_reg     <= tx_bit_reg + 4'h1;
          txd_reg        <= tx_shifter_reg[1];
          if (tx_bit_reg == nbits - 4'h1) begin
            tx_state_reg <= sync_mode ? SCR_IDLE : SCR_STOP;
            txd_reg      <= sync_mode ? 1'b1 : (has_extra ? tx_extra_reg : 1'b1);
          end
        end
        SCR_STOP: if (tx_bit_end) begin
          // With an extra bit, the first pass ends it and the second ends the stop bit
          txd_reg      <= 1'b1;
          tx_extra_reg <= 1'b0;
          tx_bit_reg   <= 4'hf;
          if (~has_extra | (tx_bit_reg == 4'hf)) tx_state_reg <= SCR_IDLE;
        end
        default: tx_state_reg <= SCR_IDLE;
      endcase
    end
  end

  // Receive engine; holding register updated only when the flags may be set
  always_ff @(posedge clock_i) begin
    if (soft_reset) begin
      rx_state_reg   <= SCR_IDLE;
      rx_shifter_reg <= 8'h00;
      rx_holding_reg <= SCR_RXHOLD_RST;
      rx_tick_reg    <= 4'h0;
      rx_bit_reg     <= 4'h0;
      rx_extra_reg   <= 1'b0;
    end else begin
      if (tick) rx_tick_reg <= rx_tick_reg + 4'h1;
      if (rx_take & ~rx_full_now) rx_holding_reg <= rx_word;
      case (rx_state_reg)
        SCR_IDLE: if (rx_start) begin
          rx_tick_reg  <= 4'h0;
          rx_bit_reg   <= sync_mode ? 4'h1 : 4'h0;
          rx_shifter_reg <= {rxd_sync_reg[1], 7'h00};
          rx_extra_reg <= 1'b0;
          rx_state_reg <= sync_mode ? SCR_DATA : SCR_START;
        end
        SCR_START: if (rx_sample) begin
          rx_state_reg <= rxd_sync_reg[1] ? SCR_IDLE : SCR_DATA;
        end
        SCR_DATA: if (rx_sample) begin
          rx_shifter_reg <= seven_bit ? {1'b0, rxd_sync_reg[1], rx_shifter_reg[6:1]}
                                      : {rxd_sync_reg[1], rx_shifter_reg[7:1]};
          rx_bit_reg     <= rx_bit_reg + 4'h1;
          if (rx_bit_reg == nbits - 4'h1) begin
            rx_state_reg <= sync_mode ? SCR_IDLE : (has_extra ? SCR_START : SCR_STOP);
            if (has_extra & ~sync_mode) rx_bit_reg <= 4'hf;
          end
        end
        SCR_STOP: if (rx_sample) rx_state_reg <= SCR_IDLE;
        default: rx_state_reg <= SCR_IDLE;
      endcase
      // Extra bit (parity or multiprocessor) collected through the start state
      if (rx_state_reg == SCR_START && rx_bit_reg == 4'hf && rx_sample) begin
        rx_extra_reg <= rxd_sync_reg[1];
        rx_state_reg <= SCR_STOP;
      end
    end
  end

  // Output ports straight from flip-flops
  assign reg_rdata_o    = rdata_reg;
  assign txd_o          = txd_reg;
  assign sck_o          = sck_out_reg;
  assign sck_oe_o       = sck_oe_reg;
  assign tx_empty_irq_o = irq_reg[3];
  assign rx_full_irq_o  = irq_reg[2];
  assign rx_error_irq_o = irq_reg[1];
  assign tx_end_irq_o   = irq_reg[0];
endmodule // scr_serial_control

/* File: sim/scr_serial_control_chk.sv */
// Port checker for the serial control register block
module scr_serial_control_chk
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       standby_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  // Serial pins
  input wire logic       rxd_i,
  input wire logic       txd_o,
  input wire logic       sck_i,
  input wire logic       sck_o,
  input wire logic       sck_oe_o,
  // Interrupt requests
  input wire logic       tx_empty_irq_o,
  input wire logic       rx_full_irq_o,
  input wire logic       rx_error_irq_o,
  input wire logic       tx_end_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_reg;
  logic       sync_reg;
  wire        clr_w = !resetn_i || standby_i;
  wire  [2:0] cfg_w = {sync_reg, ctl_reg[1:0]};
  // Shadow of what software wrote; the auto-cleared bit 3 is masked below
  always_ff @(posedge clock_i) begin
    if (clr_w) begin
      ctl_reg  <= 8'h00;
      sync_reg <= 1'b0;
    end else if (reg_write_i && reg_addr_i == SCR_ADDR_CONTROL) begin
      ctl_reg <= reg_wdata_i;
    end else if (reg_write_i && reg_addr_i == SCR_ADDR_FORMAT) begin
      sync_reg <= reg_wdata_i[SCR_FMT_SYNC];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (clr_w);
  sequence s_ctl_read;
    reg_read_i && reg_addr_i == SCR_ADDR_CONTROL;
  endsequence
  sequence s_tx_off_armed;
    (ctl_reg[SCR_CTL_TIE] && !ctl_reg[SCR_CTL_TE]) [*3];
  endsequence
  a_ctl_readback: assert property (s_ctl_read |=>
    (reg_rdata_o & 8'hf7) == ($past(ctl_reg) & 8'hf7)) else $error("control readback wrong");
  a_rdata_quiet: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
    else $error("read data without read");
  a_tx_empty_gate: assert property (!$past(ctl_reg[SCR_CTL_TIE]) |-> !tx_empty_irq_o)
    else $error("empty request while disabled");
  a_rx_req_gate: assert property (!$past(ctl_reg[SCR_CTL_RIE]) |->
    !rx_full_irq_o && !rx_error_irq_o) else $error("receive request while disabled");
  a_tx_end_gate: assert property (!$past(ctl_reg[SCR_CTL_TX_END_IRQ_EN]) |-> !tx_end_irq_o)
    else $error("end request while disabled");
  a_empty_forced: assert property (s_tx_off_armed |=> tx_empty_irq_o)
    else $error("empty flag not held with transmit off");
  a_sck_dir: assert property ($stable(cfg_w) && $past(cfg_w) == $past(cfg_w, 2) |->
    sck_oe_o == (!cfg_w[1] && (cfg_w[2] || cfg_w[0]))) else $error("clock pin direction wrong");
  a_reset_outputs: assert property ($rose(resetn_i) |-> sck_oe_o == 1'b0 && txd_o &&
    !tx_empty_irq_o && !tx_end_irq_o) else $error("outputs not at reset values");
endmodule // scr_serial_control_chk

bind scr_serial_control scr_serial_control_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .standby_i(standby_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .rxd_i(rxd_i), .txd_o(txd_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
  .tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
  .rx_error_irq_o(rx_error_irq_o), .tx_end_irq_o(tx_end_irq_o));

/* File: sim/scr_remote_station.sv */
// Remote serial station: sends frames to the block and collects what it transmits
module scr_remote_station (
  // Clock
  input  wire logic       clock_i,
  // Serial lines
  input  wire logic       txd_i,
  output logic            rxd_o,
  output logic            sck_o,
  // Collected character
  output logic [7:0]      rx_data_o,
  output logic            rx_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Marking line at rest; link clock stands still between frames
  initial begin
    rxd_o = 1'b1;
    sck_o = 1'b1;
    rx_data_o = 8'h00;
    rx_done_o = 1'b0;
  end
  // One bit time: own 32-clock timing, or sixteen link ticks of 80 ns
  task automatic bit_wait(input bit ext);
    if (ext) begin
      repeat (16) begin
        #40 sck_o <= 1'b0;
        #40 sck_o <= 1'b1;
      end
    end else begin
      repeat (32) @(posedge clock_i);
      #2;
    end
  endtask
  // Start, eight data bits LSB first, optional multiprocessor bit, stop
  task automatic send(input logic [7:0] d, input bit mp, input bit multiproc_rx_bit, input bit ext);
    rxd_o <= 1'b0;
    bit_wait(ext);
    for (int i = 0; i < 8; i++) begin
      rxd_o <= d[i];
      bit_wait(ext);
    end
    if (mp) begin
      rxd_o <= multiproc_rx_bit;
      bit_wait(ext);
    end
    rxd_o <= 1'b1;
    bit_wait(ext);
  endtask
  // Mid-bit sampling of frames from the block; only 8N1 is understood
  always begin
    @(negedge txd_i);
    repeat (16) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (32) @(posedge clock_i);
      rx_data_o[i] = txd_i;
    end
    rx_done_o = ~rx_done_o;
    repeat (32) @(posedge clock_i);
  end
endmodule // scr_remote_station

/* File: sim/tb.sv */
// Self-checking bench for the serial control register block
module tb;
  import scr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i, resetn_i, standby_i, reg_write_i, reg_read_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, rx_data, rv;
  logic       txd_o, sck_o, sck_oe_o, rxd_line, rem_sck, rx_done;
  logic       tx_empty_irq_o, rx_full_irq_o, rx_error_irq_o, tx_end_irq_o;
  int         errors, cmp_count;
  logic [23:0] pin_tab [5] = '{24'h000000, 24'h000101, 24'h800001, 24'h000200, 24'h800300};
  wire  [3:0] irq_w = {tx_empty_irq_o, rx_full_irq_o, rx_error_irq_o, tx_end_irq_o};
  wire        sck_line = sck_oe_o ? sck_o : rem_sck; // Resolved clock pin level

  scr_serial_control u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .rxd_i(rxd_line), .txd_o(txd_o),
    .sck_i(sck_line), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .tx_empty_irq_o(tx_empty_irq_o),
    .rx_full_irq_o(rx_full_irq_o), .rx_error_irq_o(rx_error_irq_o),
    .tx_end_irq_o(tx_end_irq_o));
  scr_remote_station u_rem (.clock_i(clock_i), .txd_i(txd_o), .rxd_o(rxd_line),
    .sck_o(rem_sck), .rx_data_o(rx_data), .rx_done_o(rx_done));

  // Free-running system clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register cycles; a spare edge after each keeps strobes from doubling up
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    @(negedge clock_i);
    d = reg_rdata_o;
    @(posedge clock_i);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask
  // Bounded wait for one request line to reach a level, sampled mid-cycle
  task automatic wait_irq(input int k, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge clock_i);
    while (irq_w[k] !== v && n < lim) begin
      @(negedge clock_i);
      n++;
    end
    chk({7'h00, irq_w[k]}, {7'h00, v});
    @(posedge clock_i);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog sized well beyond the six frames of the run
  initial begin
    repeat (30000) @(posedge clock_i);
    errors++;
    complete_run;
  end
  // Main sequence
  initial begin
    int n;
    errors = 0;
    cmp_count = 0;
    {resetn_i, standby_i, reg_write_i, reg_read_i} = 4'h0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    rd_chk(SCR_ADDR_CONTROL, SCR_CONTROL_RST);
    rd_chk(SCR_ADDR_STATUS, SCR_STATUS_RST);
    rd_chk(4'h9, 8'h00);
    wr(SCR_ADDR_CONTROL, 8'hf7);
    rd_chk(SCR_ADDR_CONTROL, 8'hf7);
    standby_i <= 1'b1;
    @(posedge clock_i);
    standby_i <= 1'b0;
    @(posedge clock_i);
    rd_chk(SCR_ADDR_CONTROL, 8'h00);
    wr(SCR_ADDR_CONTROL, 8'h80);
    wait_irq(3, 1'b1, 4);
    wr(SCR_ADDR_CONTROL, 8'h00);
    wait_irq(3, 1'b0, 2);
    // One character out, then a clear attempt without a prior read
    wr(SCR_ADDR_CONTROL, 8'ha4);
    wr(SCR_ADDR_TXHOLD, 8'h5a);
    rd_chk(SCR_ADDR_STATUS, 8'h84);
    wr(SCR_ADDR_STATUS, 8'h00);
    wait_irq(0, 1'b0, 1);
    wait_irq(3, 1'b1, 8);
    wr(SCR_ADDR_STATUS, 8'h00);
    wait_irq(3, 1'b1, 1);
    wait_irq(0, 1'b1, 400);
    repeat (40) @(posedge clock_i);
    chk(rx_data, 8'h5a);
    chk({7'h00, rx_done}, 8'h01);
    wr(SCR_ADDR_CONTROL, 8'ha0);
    wait_irq(0, 1'b0, 2);
    // Receive, overrun, receiver off, then clear
    wr(SCR_ADDR_CONTROL, 8'h50);
    u_rem.send(8'hc3, 1'b0, 1'b0, 1'b0);
    wait_irq(2, 1'b1, 200);
    rd_chk(SCR_ADDR_RXHOLD, 8'hc3);
    u_rem.send(8'h3c, 1'b0, 1'b0, 1'b0);
    wait_irq(1, 1'b1, 200);
    wr(SCR_ADDR_CONTROL, 8'h40);
    rd(SCR_ADDR_STATUS, rv);
    chk(rv & 8'h60, 8'h60);
    wr(SCR_ADDR_STATUS, 8'h00);
    wait_irq(2, 1'b0, 2);
    wait_irq(1, 1'b0, 2);
    // Multiprocessor wake-up
    wr(SCR_ADDR_FORMAT, 8'h04);
    wr(SCR_ADDR_CONTROL, 8'h58);
    rd_chk(SCR_ADDR_CONTROL, 8'h58);
    u_rem.send(8'h11, 1'b1, 1'b0, 1'b0);
    repeat (40) @(posedge clock_i);
    wait_irq(2, 1'b0, 1);
    u_rem.send(8'h22, 1'b1, 1'b1, 1'b0);
    wait_irq(2, 1'b1, 200);
    rd_chk(SCR_ADDR_CONTROL, 8'h50);
    rd(SCR_ADDR_STATUS, rv);
    chk(rv & 8'h42, 8'h42);
    wr(SCR_ADDR_STATUS, 8'h00);
    // Clock pin direction for each mode and clock setting
    for (int i = 0; i < 5; i++) begin
      wr(SCR_ADDR_FORMAT, pin_tab[i][23:16]);
      wr(SCR_ADDR_CONTROL, pin_tab[i][15:8]);
      @(negedge clock_i);
      chk({7'h00, sck_oe_o}, pin_tab[i][7:0]);
      @(posedge clock_i);
    end
    wr(SCR_ADDR_FORMAT, 8'h84);
    wr(SCR_ADDR_CONTROL, 8'h08);
    rd_chk(SCR_ADDR_CONTROL, 8'h00);
    // Async clock output at the bit rate: high for half a bit time
    wr(SCR_ADDR_FORMAT, 8'h00);
    wr(SCR_ADDR_CONTROL, 8'h01);
    @(posedge sck_o);
    @(negedge clock_i);
    n = 0;
    while (sck_o === 1'b1 && n < 40) begin
      n++;
      @(negedge clock_i);
    end
    chk(n[7:0], 8'h10);
    @(posedge clock_i);
    // Receive on the external link clock
    wr(SCR_ADDR_FORMAT, 8'h00);
    wr(SCR_ADDR_CONTROL, 8'h52);
    u_rem.send(8'ha5, 1'b0, 1'b0, 1'b1);
    wait_irq(2, 1'b1, 300);
    rd_chk(SCR_ADDR_RXHOLD, 8'ha5);
    complete_run;
  end
endmodule // tb
